// ---- gif_flags_top.sv ----
// global interrupt flags (bits 0 to 18) with apb register slave
//
// How it works
// [RULE1] device role: bit 18 follows pending in endpoints
// [RULE2] device role: bit 15 at chosen frame point
// [RULE3] device role: bit 14 on dropped iso packet
// [RULE4] device role: bit 13 on enumeration, speed readable
// [RULE5] device role: bit 12 on bus reset
// [RULE6] device role: 3 ms idle sets suspend bit 11
// [RULE7] device role: 3 ms idle sets bit 10
// [RULE8] bit 7 only after out nak effective
// [RULE9] bit 6 only after in nak effective
// [RULE10] host role: bit 5 half/empty by threshold
// [RULE11] bit 4 while rx fifo not empty
// [RULE12] host role: bit 3 on sof send, w1c
// [RULE13] device role: bit 3 on sof, frame readable
// [RULE14] bit 2 follows pending otg flags
// [RULE15] wrong-role register access: bit 1, no effect
// [RULE16] bit 0 shows role, 1 host
// [RULE17] software writes reserved bits only as zero
// [RULE18] role-specific flags never raised in other role
// [RULE19] flags set regardless of enable bits
// [RULE20] w1c bits vs read-only bits as listed
// [RULE21] irq while any flag and enable both set
`timescale 1ns/10ps
module gif_flags_top
  import gif_pkg::*;
#(
  parameter int IDLE_CYCLES = GIF_IDLE_CYCLES  // shorten for simulation
) (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        host_role_pin,
  input  wire logic        line_idle_pin,
  input  wire logic        in_ep_pending,
  input  wire logic        iso_out_drop_evt,
  input  wire logic        enum_done_evt,
  input  wire logic [1:0]  enum_speed,
  input  wire logic        usb_reset_evt,
  input  wire logic        sof_rx_evt,
  input  wire logic [10:0] frame_number,
  input  wire logic        sof_tx_evt,
  input  wire logic [9:0]  frame_time_us,
  input  wire logic        rx_fifo_not_empty,
  input  wire logic        np_tx_half_empty,
  input  wire logic        np_tx_empty,
  input  wire logic        otg_flags_pending,
  input  wire logic        out_nak_effective,
  input  wire logic        in_nak_effective,
  output logic             out_nak_request,
  output logic             in_nak_request,
  output logic             core_irq
);

  //////////////////////////////////////////////////////////////////////
  // address decode helpers
  function automatic logic is_dev_reg(input logic [7:0] a);
    is_dev_reg = (a == GIF_OFS_DEV_CFG) || (a == GIF_OFS_DEV_CTL) ||
                 (a == GIF_OFS_DEV_STAT);
  endfunction : is_dev_reg

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = is_dev_reg(a) || (a == GIF_OFS_BUS_CFG) ||
                (a == GIF_OFS_HOST_CFG) || (a == GIF_OFS_FLAGS) ||
                (a == GIF_OFS_ENABLES);
  endfunction : is_mapped

  //////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic host_role;   // synced role level
  logic line_idle;   // synced idle level
  logic idle_fire;   // idle period reached

  gif_sync #(.WIDTH(2)) u_sync (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .async_in ({host_role_pin, line_idle_pin}),
    .sync_out ({host_role, line_idle})
  );

  gif_idle_timer #(.IDLE_CYCLES(IDLE_CYCLES)) u_idle (
    .core_clk      (core_clk),
    .rst_b         (rst_b),
    .idle          (line_idle & ~host_role),
    .expired_pulse (idle_fire)
  );

  //////////////////////////////////////////////////////////////////////
  // registers
  logic [31:0] flags_reg;      // sticky w1c and level flags
  logic [31:0] flags_next;
  logic [31:0] enables_reg;    // interrupt enables
  logic [1:0]  eop_pt_reg;     // periodic_frame_end_point
  logic        tx_fifo_empty_threshold_reg;      // tx_fifo_empty_threshold
  logic [31:0] host_cfg_reg;   // host-only config word
  logic [1:0]  speed_reg;      // enumerated speed
  logic [10:0] frame_reg;      // last frame number
  logic        out_nak_reg;    // global out nak active
  logic        in_nak_reg;     // global in nak active

  //////////////////////////////////////////////////////////////////////
  // apb decode
  wire dev_role   = ~host_role;
  wire setup_ph   = psel & penable & ~pready;
  wire commit     = psel & penable & pready;
  wire mapped     = is_mapped(paddr);
  wire role_fault = (is_dev_reg(paddr) & host_role) |
                    ((paddr == GIF_OFS_HOST_CFG) & dev_role);
  wire wr_ok      = commit & pwrite & mapped & ~role_fault;
  wire wr_flags   = wr_ok & (paddr == GIF_OFS_FLAGS);
  wire wr_en      = wr_ok & (paddr == GIF_OFS_ENABLES);
  wire wr_dcfg    = wr_ok & (paddr == GIF_OFS_DEV_CFG);
  wire wr_dctl    = wr_ok & (paddr == GIF_OFS_DEV_CTL);
  wire wr_bcfg    = wr_ok & (paddr == GIF_OFS_BUS_CFG);
  wire wr_hcfg    = wr_ok & (paddr == GIF_OFS_HOST_CFG);
  wire fault_evt  = commit & mapped & role_fault;  // [RULE15]

  //////////////////////////////////////////////////////////////////////
  // event sources
  wire [9:0] eop_us = (eop_pt_reg == 2'h0) ? GIF_EOP_US_80 :
                      (eop_pt_reg == 2'h1) ? GIF_EOP_US_85 :
                      (eop_pt_reg == 2'h2) ? GIF_EOP_US_90 : GIF_EOP_US_95;
  wire eop_evt   = dev_role & (frame_time_us == eop_us);       // [RULE2]
  wire iso_evt   = dev_role & iso_out_drop_evt;                 // [RULE3]
  wire enum_evt  = dev_role & enum_done_evt;                    // [RULE4]
  wire rst_evt   = dev_role & usb_reset_evt;                    // [RULE5]
  wire susp_evt  = dev_role & idle_fire;                        // [RULE6] [RULE7]
  wire sof_evt   = host_role ? sof_tx_evt : sof_rx_evt;         // [RULE12] [RULE13]
  wire nptx_lvl  = host_role & (tx_fifo_empty_threshold_reg ? np_tx_empty : np_tx_half_empty); // [RULE10]

  // set events per bit, used by the sticky logic
  wire [31:0] set_vec = (32'(eop_evt)   << GIF_B_EOPF)  |
                        (32'(iso_evt)   << GIF_B_ISODROP) |
                        (32'(enum_evt)  << GIF_B_ENUM)  |
                        (32'(rst_evt)   << GIF_B_RST)   |
                        (32'(susp_evt)  << GIF_B_SUSP)  |
                        (32'(susp_evt)  << GIF_B_ESUSP) |
                        (32'(sof_evt)   << GIF_B_SOF)   |
                        (32'(fault_evt) << GIF_B_FAULT);

  // level flags that track their source
  wire [31:0] lvl_vec = (32'(dev_role & in_ep_pending)  << GIF_B_INEP)   |  // [RULE1] [RULE18]
                        (32'(dev_role & out_nak_effective & out_nak_reg)
                                                          << GIF_B_OUTNAK) |  // [RULE8]
                        (32'(dev_role & in_nak_effective & in_nak_reg)
                                                          << GIF_B_INNAK)  |  // [RULE9]
                        (32'(nptx_lvl)                   << GIF_B_NPTXE)  |
                        (32'(rx_fifo_not_empty)          << GIF_B_RXNE)   |  // [RULE11]
                        (32'(otg_flags_pending)          << GIF_B_OTG)    |  // [RULE14]
                        (32'(host_role)                  << GIF_B_ROLE);     // [RULE16]

  wire [31:0] clr_vec = wr_flags ? (pwdata & GIF_W1C_MASK) : 32'h0000_0000;

  // sticky bits: set wins over clear, levels replace read-only bits
  assign flags_next = (((flags_reg & ~clr_vec) | set_vec) & GIF_W1C_MASK) |
                      lvl_vec;                                   // [RULE20] [RULE19]

  //////////////////////////////////////////////////////////////////////
  // read mux
  wire [31:0] dstat_word = (32'(speed_reg) << GIF_DSTAT_SPD_LSB) |
                           (32'(frame_reg) << GIF_DSTAT_FRM_LSB);
  wire [31:0] rd_word =
    role_fault                    ? 32'h0000_0000 :
    (paddr == GIF_OFS_FLAGS)      ? flags_reg :
    (paddr == GIF_OFS_ENABLES)    ? enables_reg :
    (paddr == GIF_OFS_DEV_CFG)    ? 32'(eop_pt_reg) :
    (paddr == GIF_OFS_DEV_CTL)    ? 32'h0000_0000 :
    (paddr == GIF_OFS_BUS_CFG)    ? (32'(tx_fifo_empty_threshold_reg) << GIF_BCFG_TX_FIFO_EMPTY_THRESHOLD) :
    (paddr == GIF_OFS_DEV_STAT)   ? dstat_word :
    (paddr == GIF_OFS_HOST_CFG)   ? host_cfg_reg : 32'h0000_0000;

  //////////////////////////////////////////////////////////////////////
  // apb handshake: one wait state, data loaded with pready
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup_ph;
      prdata  <= setup_ph & ~pwrite ? rd_word : 32'h0000_0000;
      pslverr <= setup_ph & ~mapped;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // flag register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      flags_reg <= 32'h0000_0000;
    end else begin
      flags_reg <= flags_next;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // software-written configuration
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      enables_reg  <= GIF_RST_ENABLES;
      eop_pt_reg   <= GIF_RST_EOP_PT;
      tx_fifo_empty_threshold_reg    <= GIF_RST_TX_FIFO_EMPTY_THRESHOLD;
      host_cfg_reg <= GIF_RST_HOST_CFG;
    end else begin
      if (wr_en)   enables_reg  <= pwdata & GIF_EN_MASK;  // [RULE17]
      if (wr_dcfg) eop_pt_reg   <= pwdata[1:0];
      if (wr_bcfg) tx_fifo_empty_threshold_reg    <= pwdata[GIF_BCFG_TX_FIFO_EMPTY_THRESHOLD];
      if (wr_hcfg) host_cfg_reg <= pwdata;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // device status capture
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      speed_reg <= 2'h0;
      frame_reg <= 11'h000;
    end else begin
      if (enum_evt)               speed_reg <= enum_speed;    // [RULE4]
      if (dev_role & sof_rx_evt)  frame_reg <= frame_number;  // [RULE13]
    end
  end

  //////////////////////////////////////////////////////////////////////
  // global nak requests: set by write, cleared by write or role change
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_nak_reg <= 1'b0;
      in_nak_reg  <= 1'b0;
    end else if (host_role) begin
      out_nak_reg <= 1'b0;
      in_nak_reg  <= 1'b0;
    end else if (wr_dctl) begin
      if (pwdata[GIF_DCTL_SET_OUTNAK])      out_nak_reg <= 1'b1;  // [RULE8]
      else if (pwdata[GIF_DCTL_CLR_OUTNAK]) out_nak_reg <= 1'b0;
      if (pwdata[GIF_DCTL_SET_INNAK])       in_nak_reg  <= 1'b1;  // [RULE9]
      else if (pwdata[GIF_DCTL_CLR_INNAK])  in_nak_reg  <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs from flops
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_nak_request <= 1'b0;
      in_nak_request  <= 1'b0;
      core_irq        <= 1'b0;
    end else begin
      out_nak_request <= out_nak_reg;
      in_nak_request  <= in_nak_reg;
      core_irq        <= |(flags_reg & enables_reg & GIF_EN_MASK);  // [RULE21]
    end
  end

  //////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sequence s_sof_seen;
    sof_evt;
  endsequence
  sequence s_flag_up;
    ##1 flags_reg[GIF_B_SOF];
  endsequence

  property p_sof_set;
    s_sof_seen |-> s_flag_up;
  endproperty
  a_sof_set: assert property (p_sof_set) else $error("sof flag not set"); // [RULE12]

  property p_role_bit;
    ##1 flags_reg[GIF_B_ROLE] == $past(host_role);
  endproperty
  a_role_bit: assert property (p_role_bit) else $error("role bit wrong"); // [RULE16]

  property p_dev_only;
    host_role [*2] |-> ##1 (flags_reg[GIF_B_INEP] == 1'b0 && flags_reg[GIF_B_OUTNAK] == 1'b0);
  endproperty
  a_dev_only: assert property (p_dev_only) else $error("device flag in host"); // [RULE18]

  property p_fault;
    fault_evt |=> flags_reg[GIF_B_FAULT] && $stable(host_cfg_reg);
  endproperty
  a_fault: assert property (p_fault) else $error("fault not flagged"); // [RULE15]

  property p_irq;
    ##1 core_irq == |($past(flags_reg) & $past(enables_reg) & GIF_EN_MASK);
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch"); // [RULE21]

  property p_w1c;
    (wr_flags && pwdata[GIF_B_RST] && !rst_evt) |=> !flags_reg[GIF_B_RST];
  endproperty
  a_w1c: assert property (p_w1c) else $error("w1c failed"); // [RULE20]

  property p_set_wins;
    (wr_flags && pwdata[GIF_B_ENUM] && enum_evt) |=> flags_reg[GIF_B_ENUM];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("set lost"); // [RULE20]

  property p_susp;
    susp_evt |=> flags_reg[GIF_B_SUSP] && flags_reg[GIF_B_ESUSP];
  endproperty
  a_susp: assert property (p_susp) else $error("suspend missing"); // [RULE6]

  property p_outnak;
    flags_reg[GIF_B_OUTNAK] |-> $past(out_nak_reg);
  endproperty
  a_outnak: assert property (p_outnak) else $error("nak flag early"); // [RULE8]

  property p_rxne;
    ##1 flags_reg[GIF_B_RXNE] == $past(rx_fifo_not_empty);
  endproperty
  a_rxne: assert property (p_rxne) else $error("rx flag wrong"); // [RULE11]

endmodule : gif_flags_top

// ---- gif_pkg.sv ----
// shared constants for the global interrupt flag block
package gif_pkg;

  // register byte offsets
  localparam logic [7:0] GIF_OFS_DEV_CFG   = 8'h00;  // device_configuration
  localparam logic [7:0] GIF_OFS_DEV_CTL   = 8'h04;  // device_control
  localparam logic [7:0] GIF_OFS_BUS_CFG   = 8'h08;  // bus_config_status
  localparam logic [7:0] GIF_OFS_DEV_STAT  = 8'h0c;  // device_status
  localparam logic [7:0] GIF_OFS_HOST_CFG  = 8'h10;  // host-only scratch config
  localparam logic [7:0] GIF_OFS_FLAGS     = 8'h14;  // global_interrupt_flags
  localparam logic [7:0] GIF_OFS_ENABLES   = 8'h18;  // global_interrupt_enables

  // flag bit positions
  localparam int GIF_B_ROLE    = 0;
  localparam int GIF_B_FAULT   = 1;
  localparam int GIF_B_OTG     = 2;
  localparam int GIF_B_SOF     = 3;
  localparam int GIF_B_RXNE    = 4;
  localparam int GIF_B_NPTXE   = 5;
  localparam int GIF_B_INNAK   = 6;
  localparam int GIF_B_OUTNAK  = 7;
  localparam int GIF_B_ESUSP   = 10;
  localparam int GIF_B_SUSP    = 11;
  localparam int GIF_B_RST     = 12;
  localparam int GIF_B_ENUM    = 13;
  localparam int GIF_B_ISODROP = 14;
  localparam int GIF_B_EOPF    = 15;
  localparam int GIF_B_INEP    = 18;

  // write-1-to-clear bits and implemented enable bits
  localparam logic [31:0] GIF_W1C_MASK = 32'h0000_fc0a;
  localparam logic [31:0] GIF_EN_MASK  = 32'h0004_fcfe;

  // field positions in control registers
  localparam int GIF_DCTL_SET_OUTNAK = 9;   // set_global_out_nak
  localparam int GIF_DCTL_CLR_OUTNAK = 10;
  localparam int GIF_DCTL_SET_INNAK  = 7;   // set_global_in_nak
  localparam int GIF_DCTL_CLR_INNAK  = 8;
  localparam int GIF_BCFG_TX_FIFO_EMPTY_THRESHOLD      = 4;   // tx_fifo_empty_threshold
  localparam int GIF_DSTAT_SPD_LSB   = 1;   // speed field [2:1]
  localparam int GIF_DSTAT_FRM_LSB   = 8;   // frame number [18:8]

  // reset values
  localparam logic [31:0] GIF_RST_ENABLES  = 32'h0000_0000;
  localparam logic [1:0]  GIF_RST_EOP_PT   = 2'h0;
  localparam logic        GIF_RST_TX_FIFO_EMPTY_THRESHOLD    = 1'b0;
  localparam logic [31:0] GIF_RST_HOST_CFG = 32'h0000_0000;

  // end-of-periodic-frame points in microseconds into the frame
  localparam logic [9:0] GIF_EOP_US_80 = 10'd800;
  localparam logic [9:0] GIF_EOP_US_85 = 10'd850;
  localparam logic [9:0] GIF_EOP_US_90 = 10'd900;
  localparam logic [9:0] GIF_EOP_US_95 = 10'd950;

  // idle time before suspend
  localparam int GIF_CLK_MHZ       = 125;
  localparam int GIF_IDLE_US       = 3000;
  localparam int GIF_IDLE_CYCLES   = GIF_IDLE_US * GIF_CLK_MHZ;

endpackage : gif_pkg

// ---- gif_sync.sv ----
// two-flop synchroniser for pin levels
`timescale 1ns/10ps
module gif_sync
  import gif_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;  // first stage, read only by second

  //////////////////////////////////////////////////////////////////////
  // two stages, constant reset
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : gif_sync

// ---- gif_idle_timer.sv ----
// bus idle timer, one pulse after a full idle period
`timescale 1ns/10ps
module gif_idle_timer
  import gif_pkg::*;
#(
  parameter int IDLE_CYCLES = GIF_IDLE_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic rst_b,
  input  wire logic idle,
  output logic      expired_pulse
);

  localparam int CW = $clog2(IDLE_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(IDLE_CYCLES - 1);

  logic [CW-1:0] cnt_reg;   // idle cycles so far
  logic          done_reg;  // period reached, wait for activity

  //////////////////////////////////////////////////////////////////////
  // count idle cycles, fire once, rearm on activity
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg       <= '0;
      done_reg      <= 1'b0;
      expired_pulse <= 1'b0;
    end else begin
      expired_pulse <= 1'b0;
      if (!idle) begin
        cnt_reg  <= '0;
        done_reg <= 1'b0;
      end else if (!done_reg) begin
        if (cnt_reg == LAST) begin
          done_reg      <= 1'b1;
          expired_pulse <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + 1'b1;
        end
      end
    end
  end

endmodule : gif_idle_timer

// ---- gif_usb_model.sv ----
// usb side model: nak handshakes of the core behind the flag block
`timescale 1ns/10ps
module gif_usb_model (
  input  wire logic core_clk,
  input  wire logic rst_b,
  input  wire logic slow,
  input  wire logic out_nak_request,
  input  wire logic in_nak_request,
  output logic      out_nak_effective,
  output logic      in_nak_effective
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] lim;      // cycles before a requested nak takes hold
  logic [7:0] out_cnt;  // out nak settle count
  logic [7:0] in_cnt;   // in nak settle count

  assign lim = slow ? 8'h06 : 8'h01;

  // nak holds only after the settle count, drops at once on release
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_cnt <= 8'h00;
      in_cnt  <= 8'h00;
    end else begin
      out_cnt <= !out_nak_request ? 8'h00 : (out_cnt == lim) ? lim : out_cnt + 8'h01;
      in_cnt  <= !in_nak_request ? 8'h00 : (in_cnt == lim) ? lim : in_cnt + 8'h01;
    end
  end

  assign out_nak_effective = out_nak_request && (out_cnt == lim);
  assign in_nak_effective  = in_nak_request && (in_cnt == lim);
endmodule : gif_usb_model

// ---- tb_top.sv ----
// self-checking testbench for the global interrupt flag block
`timescale 1ns/10ps
module tb_top;
  import gif_pkg::*;
  localparam int IDLE = 20;  // shortened idle period
  ////////////////////////////////////////////////////////////////////////////
  logic        core_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, pready, pslverr, core_irq, nak_slow = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        host_role_pin = 1'b0, line_idle_pin = 1'b0, in_ep_pending = 1'b0;
  logic        iso_out_drop_evt = 1'b0, enum_done_evt = 1'b0, usb_reset_evt = 1'b0;
  logic        sof_rx_evt = 1'b0, sof_tx_evt = 1'b0, rx_fifo_not_empty = 1'b0;
  logic        np_tx_half_empty = 1'b0, np_tx_empty = 1'b0, otg_flags_pending = 1'b0;
  logic        out_nak_effective, in_nak_effective, out_nak_request, in_nak_request;
  logic [1:0]  enum_speed = 2'h0, sp;
  logic [10:0] frame_number = 11'h0, fr;
  logic [9:0]  frame_time_us = 10'h0;
  logic [9:0]  pts [4];
  logic [32:0] exp_q [$];  // expected {pslverr, prdata} per read
  int          n_mismatch = 0;
  int          num_checks = 0;

  always #4 core_clk = ~core_clk;

  gif_flags_top #(.IDLE_CYCLES(IDLE)) gif_flags_top_inst (
    .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .host_role_pin(host_role_pin),
    .line_idle_pin(line_idle_pin), .in_ep_pending(in_ep_pending),
    .iso_out_drop_evt(iso_out_drop_evt), .enum_done_evt(enum_done_evt),
    .enum_speed(enum_speed), .usb_reset_evt(usb_reset_evt), .sof_rx_evt(sof_rx_evt),
    .frame_number(frame_number), .sof_tx_evt(sof_tx_evt), .frame_time_us(frame_time_us),
    .rx_fifo_not_empty(rx_fifo_not_empty), .np_tx_half_empty(np_tx_half_empty),
    .np_tx_empty(np_tx_empty), .otg_flags_pending(otg_flags_pending),
    .out_nak_effective(out_nak_effective), .in_nak_effective(in_nak_effective),
    .out_nak_request(out_nak_request), .in_nak_request(in_nak_request),
    .core_irq(core_irq));

  gif_usb_model gif_usb_model_inst (
    .core_clk(core_clk), .rst_b(rst_b), .slow(nak_slow),
    .out_nak_request(out_nak_request), .in_nak_request(in_nak_request),
    .out_nak_effective(out_nak_effective), .in_nak_effective(in_nak_effective));

  ////////////////////////////////////////////////////////////////////////////
  // compare and count
  task check(input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // verdict and end of run
  task complete_run;
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  function automatic logic [31:0] bit_of(input int i);
    return 32'h1 << i;
  endfunction : bit_of

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    int n = 0;
    @(posedge core_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    if (!w) exp_q.push_back(e);
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) n_mismatch++;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, e});
  endtask : rd

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask : idle

  // read answers matched against the oldest note
  always @(posedge core_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (exp_q.size() == 0) n_mismatch++;
      else check({pslverr, prdata}, exp_q.pop_front());
    end
  end

  // watchdog
  initial begin
    #200000;
    n_mismatch++;
    complete_run;
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    pts = '{GIF_EOP_US_80, GIF_EOP_US_85, GIF_EOP_US_90, GIF_EOP_US_95};
    void'($urandom(32'hbf68));
    idle(8);
    rst_b <= 1'b1;
    rd(GIF_OFS_FLAGS, 32'h0);
    rd(GIF_OFS_ENABLES, GIF_RST_ENABLES);
    // device events with captured speed and frame
    sp = 2'($urandom);
    fr = 11'($urandom);
    enum_speed <= sp;
    frame_number <= fr;
    {usb_reset_evt, enum_done_evt, sof_rx_evt, iso_out_drop_evt} <= 4'hf;
    {in_ep_pending, rx_fifo_not_empty, otg_flags_pending} <= 3'h7;
    @(posedge core_clk);
    {usb_reset_evt, enum_done_evt, sof_rx_evt, iso_out_drop_evt} <= 4'h0;
    enum_speed <= ~sp;
    frame_number <= ~fr;
    idle(3);
    #1 check({32'h0, core_irq}, 33'h0);
    rd(GIF_OFS_FLAGS, bit_of(GIF_B_RST) | bit_of(GIF_B_ENUM) | bit_of(GIF_B_SOF)
       | bit_of(GIF_B_ISODROP) | bit_of(GIF_B_INEP) | bit_of(GIF_B_RXNE)
       | bit_of(GIF_B_OTG));
    rd(GIF_OFS_DEV_STAT, (32'(fr) << 8) | (32'(sp) << 1));
    wr(GIF_OFS_ENABLES, bit_of(GIF_B_RST));
    idle(3);
    #1 check({32'h0, core_irq}, 33'h1);
    wr(GIF_OFS_FLAGS, GIF_W1C_MASK | bit_of(GIF_B_RXNE) | bit_of(GIF_B_OTG));
    idle(3);
    #1 check({32'h0, core_irq}, 33'h0);
    rd(GIF_OFS_FLAGS, bit_of(GIF_B_INEP) | bit_of(GIF_B_RXNE) | bit_of(GIF_B_OTG));
    {in_ep_pending, rx_fifo_not_empty, otg_flags_pending} <= 3'h0;
    rd(GIF_OFS_FLAGS, 32'h0);
    wr(GIF_OFS_ENABLES, GIF_EN_MASK);
    rd(GIF_OFS_ENABLES, GIF_EN_MASK);
    wr(GIF_OFS_ENABLES, 32'h0);
    // event on the clearing edge: the set must win
    enum_done_evt <= 1'b1;
    wr(GIF_OFS_FLAGS, bit_of(GIF_B_ENUM));
    enum_done_evt <= 1'b0;
    rd(GIF_OFS_FLAGS, bit_of(GIF_B_ENUM));
    wr(GIF_OFS_FLAGS, bit_of(GIF_B_ENUM));
    // end-of-periodic-frame point for every code
    for (int k = 0; k < 4; k++) begin
      wr(GIF_OFS_DEV_CFG, 32'(k));
      frame_time_us <= pts[k] - 10'd1;
      idle(2);
      rd(GIF_OFS_FLAGS, 32'h0);
      frame_time_us <= pts[k];
      idle(2);
      frame_time_us <= 10'h0;
      rd(GIF_OFS_FLAGS, bit_of(GIF_B_EOPF));
      wr(GIF_OFS_FLAGS, bit_of(GIF_B_EOPF));
    end
    // global naks, slow then prompt partner
    nak_slow <= 1'b1;
    wr(GIF_OFS_DEV_CTL, bit_of(GIF_DCTL_SET_OUTNAK));
    rd(GIF_OFS_FLAGS, 32'h0);
    idle(10);
    rd(GIF_OFS_FLAGS, bit_of(GIF_B_OUTNAK));
    wr(GIF_OFS_DEV_CTL, bit_of(GIF_DCTL_CLR_OUTNAK));
    nak_slow <= 1'b0;
    wr(GIF_OFS_DEV_CTL, bit_of(GIF_DCTL_SET_INNAK));
    idle(10);
    rd(GIF_OFS_FLAGS, bit_of(GIF_B_INNAK));
    wr(GIF_OFS_DEV_CTL, bit_of(GIF_DCTL_CLR_INNAK));
    idle(3);
    rd(GIF_OFS_FLAGS, 32'h0);
    // idle bus: suspend and early suspend
    line_idle_pin <= 1'b1;
    idle(IDLE + 8);
    line_idle_pin <= 1'b0;
    rd(GIF_OFS_FLAGS, bit_of(GIF_B_SUSP) | bit_of(GIF_B_ESUSP));
    wr(GIF_OFS_FLAGS, GIF_W1C_MASK);
    // host role
    host_role_pin <= 1'b1;
    idle(5);
    {usb_reset_evt, sof_tx_evt, iso_out_drop_evt} <= 3'h7;
    {np_tx_half_empty, in_ep_pending} <= 2'h3;
    line_idle_pin <= 1'b1;
    @(posedge core_clk);
    {usb_reset_evt, sof_tx_evt, iso_out_drop_evt} <= 3'h0;
    idle(IDLE + 8);
    line_idle_pin <= 1'b0;
    rd(GIF_OFS_FLAGS, bit_of(GIF_B_ROLE) | bit_of(GIF_B_SOF) | bit_of(GIF_B_NPTXE));
    wr(GIF_OFS_FLAGS, bit_of(GIF_B_SOF));
    wr(GIF_OFS_BUS_CFG, bit_of(GIF_BCFG_TX_FIFO_EMPTY_THRESHOLD));
    idle(2);
    rd(GIF_OFS_FLAGS, bit_of(GIF_B_ROLE));
    np_tx_empty <= 1'b1;
    wr(GIF_OFS_DEV_CFG, 32'h0);
    rd(GIF_OFS_FLAGS, bit_of(GIF_B_ROLE) | bit_of(GIF_B_NPTXE)
       | bit_of(GIF_B_FAULT));
    wr(GIF_OFS_FLAGS, bit_of(GIF_B_FAULT));
    {np_tx_half_empty, np_tx_empty, in_ep_pending} <= 3'h0;
    host_role_pin <= 1'b0;
    idle(5);
    rd(GIF_OFS_DEV_CFG, 32'h3);
    wr(GIF_OFS_HOST_CFG, 32'h5a);
    rd(GIF_OFS_FLAGS, bit_of(GIF_B_FAULT));
    apb(1'b0, 8'h1c, 32'h0, {1'b1, 32'h0});
    // let the monitor take the last answer, then no note may be left over
    idle(2);
    if (exp_q.size() != 0) n_mismatch++;
    complete_run;
  end
endmodule : tb_top
